// *** hdl/keypad_detect.sv ***
/*
 * edge and level detection of the enabled keypad pins.
 * assumes synchronised pins of raw polarity, normalised here: low is asserted unless the invert bit is set.
 */
`timescale 1ns/1ns
`default_nettype none
module keypad_detect #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // configuration
    input  wire logic [WIDTH-1:0] enable,
    input  wire logic [WIDTH-1:0] invert,
    input  wire logic             level_mode,
    // pins and results
    input  wire logic [WIDTH-1:0] pins_sync,
    output logic                  edge_hit,
    output logic                  level_hit
);
    logic [WIDTH-1:0] asserted;
    logic [WIDTH-1:0] prev_q;
    logic [WIDTH-1:0] rose;
    logic [WIDTH-1:0] others_idle;
    logic             armed_q;

    // asserted level is low unless the pin is inverted to sense high
    assign asserted = enable & (pins_sync ^ ~invert);
    assign rose     = asserted & ~prev_q;
    assign others_idle = asserted & ~rose;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_q  <= '0;
            armed_q <= 1'b0;
        end else begin
            prev_q  <= asserted;
            // arms once all enabled pins are deasserted in the same cycle
            armed_q <= (armed_q | (asserted == '0)) & (enable != '0);
        end
    end

    always_comb begin
        edge_hit  = armed_q & (rose != '0) & (!level_mode | (others_idle == '0));
        level_hit = level_mode & (asserted != '0);
    end
endmodule
`default_nettype wire

// *** hdl/keypad_map.svh ***
/*
 * register offsets, field positions and reset values of the keypad wake unit.
 * assumes inclusion by bare name from the design files.
 */
`ifndef KEYPAD_MAP_SVH
`define KEYPAD_MAP_SVH

`define KP_OFS_STATUS_CONTROL 5'h00
`define KP_OFS_PIN_ENABLE     5'h04
`define KP_OFS_EVENT_STATUS   5'h08
`define KP_OFS_EVENT_CLEAR    5'h0c
`define KP_OFS_EVENT_ENABLE   5'h10
`define KP_OFS_LOW_POWER      5'h14

`define KP_BIT_MODE           0
`define KP_BIT_IRQ_EN         1
`define KP_BIT_ACK            2
`define KP_BIT_FLAG           3
`define KP_POL_LSB            4
`define KP_POL_MSB            7
`define KP_FIXED_MSB          3

`define KP_BIT_STOP           0
`define KP_BIT_WAIT           1

`define KP_EVT_FLAG           0
`define KP_EVT_WAKE           1
`define KP_EVT_WIDTH          2

`define KP_RESET_BYTE         8'h00
`define KP_RESET_EVT          2'h0
`define KP_RESET_LP           2'h0
`define KP_RESP_OKAY          2'h0
`define KP_RESP_SLVERR        2'h2

`endif

// *** hdl/keypad_pkg.sv ***
/*
 * types shared by the keypad wake unit files.
 * assumes no surroundings beyond the map header.
 */
package keypad_pkg;
    typedef enum logic [1:0] {
        wr_idle,
        wr_resp
    } wr_state_t;
    typedef logic [7:0] byte_t;
endpackage

// *** hdl/keypad_wake_unit.sv ***
/*
 * keypad wake unit: up to eight keypad pins, one pending flag, irq, wake,
 * pull-down enables and an AXI4-Lite register slave.
 * assumes pins are asynchronous and low-power mode is reported by software.
 */
// Design decisions made here: the register offsets and the AXI4-Lite slave port.
// Functional notes
// - eight keypad pins, the lower four always sense falling edges or low levels.
// - polarity bits 7:4 pick falling/low at 0 and rising/high at 1 for the upper pins.
// - the mode bit picks edge-only at 0 and edge-and-level at 1 for all enabled pins.
// - the read-only pending flag in bit 3 sets on any detected trigger event.
// - writing 1 to the acknowledge bit clears the flag in edge-only mode, unless an edge sets it in the same cycle.
// - in edge-and-level mode an asserted enabled pin keeps re-setting the flag.
// - the acknowledge bit 2 is write-only and reads as 0.
// - with irq enable bit 1 set an interrupt is requested while the flag is 1.
// - each pin enable bit makes its pin a keypad input, otherwise it adds nothing.
// - the pull-down enable is on for an enabled pin whose polarity selects rising.
// - a keypad event on an enabled pin wakes the processor from stop and wait.
// - a falling edge is a 1 sampled in one cycle and 0 in the next.
// - a rising edge is a 0 sampled in one cycle and 1 in the next.
// - edges count only after the pins were deasserted, and alone in level mode.
// - in stop mode the enabled inputs wake as plain levels without edge detection.
`timescale 1ns/1ns
`default_nettype none
`include "keypad_map.svh"
module keypad_wake_unit
    import keypad_pkg::*;
#(
    parameter int PINS = 8
) (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // write address channel
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // write data channel
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // write response channel
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // read address channel
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // read data channel
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // keypad pins
    input  wire logic [7:0]  keypad_pins,
    output logic [7:0]       pull_down_en,
    // processor side
    output logic             irq,
    output logic             wake_req
);
    byte_t            status_control_q;
    byte_t            pin_enable_q;
    logic [1:0]       evt_status_q;
    logic [1:0]       evt_enable_q;
    logic [1:0]       low_power_q;
    logic [7:0]       pins_sync;
    logic [7:0]       invert;
    logic             edge_hit;
    logic             level_hit;
    logic             flag_set;
    logic             wake_now;
    logic             ack_wr;
    wr_state_t        wr_state_q;
    logic             aw_have_q;
    logic             w_have_q;
    logic [31:0]      aw_addr_q;
    logic [31:0]      w_data_q;
    logic [3:0]       w_strb_q;
    logic             wr_fire;
    logic [4:0]       wr_ofs;
    logic [4:0]       rd_ofs;
    logic             wr_hit;
    logic             flag_q;
    byte_t            status_view;

    genvar g;
    generate
        for (g = 0; g < PINS; g++) begin : g_sync
            pin_sync u_sync (
                .aclk    (aclk),
                .aresetn (aresetn),
                .pin_in  (keypad_pins[g]),
                .pin_out (pins_sync[g])
            );
        end
    endgenerate

    // lower nibble sense is fixed to falling/low
    assign invert = {status_control_q[`KP_POL_MSB:`KP_POL_LSB], 4'h0};

    keypad_detect #(
        .WIDTH (PINS)
    ) u_detect (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .enable     (pin_enable_q),
        .invert     (invert),
        .level_mode (status_control_q[`KP_BIT_MODE]),
        .pins_sync  (pins_sync),
        .edge_hit   (edge_hit),
        .level_hit  (level_hit)
    );

    assign flag_set = edge_hit | level_hit;
    // in stop the raw level of an enabled pin wakes, bypassing edge logic
    assign wake_now = (low_power_q[`KP_BIT_STOP] & ((pin_enable_q & (keypad_pins ^ ~invert)) != '0))
                    | ((low_power_q[`KP_BIT_STOP] | low_power_q[`KP_BIT_WAIT]) & flag_set);

    // write path: address and data accepted in either order
    assign wr_fire = aw_have_q & w_have_q & (wr_state_q == wr_idle);
    assign wr_ofs  = aw_addr_q[4:0];
    assign rd_ofs  = s_axi_araddr[4:0];
    // only aligned words up to the low power register are mapped
    assign wr_hit  = (aw_addr_q[31:5] == '0) & (wr_ofs[1:0] == 2'h0)
                   & (wr_ofs <= `KP_OFS_LOW_POWER);
    assign ack_wr  = wr_fire & wr_hit & (wr_ofs == `KP_OFS_STATUS_CONTROL)
                   & w_strb_q[0] & w_data_q[`KP_BIT_ACK];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            aw_addr_q     <= '0;
            w_data_q      <= '0;
            w_strb_q      <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            s_axi_awready <= ~aw_have_q & ~s_axi_awready & s_axi_awvalid & (wr_state_q == wr_idle);
            s_axi_wready  <= ~w_have_q & ~s_axi_wready & s_axi_wvalid & (wr_state_q == wr_idle);
            if (s_axi_awvalid & s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_have_q <= 1'b0;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_have_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_q   <= wr_idle;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `KP_RESP_OKAY;
        end else begin
            unique case (wr_state_q)
                wr_idle: begin
                    if (wr_fire) begin
                        wr_state_q   <= wr_resp;
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp  <= wr_hit ? `KP_RESP_OKAY : `KP_RESP_SLVERR;
                    end
                end
                wr_resp: begin
                    if (s_axi_bready) begin
                        wr_state_q   <= wr_idle;
                        s_axi_bvalid <= 1'b0;
                    end
                end
            endcase
        end
    end

    // configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_control_q <= `KP_RESET_BYTE;
            pin_enable_q     <= `KP_RESET_BYTE;
            evt_enable_q     <= `KP_RESET_EVT;
            low_power_q      <= `KP_RESET_LP;
        end else if (wr_fire & wr_hit & w_strb_q[0]) begin
            unique case (wr_ofs)
                `KP_OFS_STATUS_CONTROL: begin
                    status_control_q[`KP_POL_MSB:`KP_POL_LSB] <= w_data_q[`KP_POL_MSB:`KP_POL_LSB];
                    status_control_q[`KP_BIT_IRQ_EN] <= w_data_q[`KP_BIT_IRQ_EN];
                    status_control_q[`KP_BIT_MODE]   <= w_data_q[`KP_BIT_MODE];
                end
                `KP_OFS_PIN_ENABLE:   pin_enable_q <= w_data_q[7:0];
                `KP_OFS_EVENT_ENABLE: evt_enable_q <= w_data_q[1:0];
                `KP_OFS_LOW_POWER:    low_power_q  <= w_data_q[1:0];
                default: ;
            endcase
        end
    end

    // pending flag: a set in the same cycle as the acknowledge wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_q <= 1'b0;
        end else if (flag_set) begin
            flag_q <= 1'b1;
        end else if (ack_wr) begin
            flag_q <= 1'b0;
        end
    end

    // read view of the status/control register: flag merged in, acknowledge reads 0
    always_comb begin
        status_view                 = status_control_q;
        status_view[`KP_BIT_FLAG]   = flag_q;
        status_view[`KP_BIT_ACK]    = 1'b0;
    end

    // sticky events: flag set and wake request
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            evt_status_q <= `KP_RESET_EVT;
        end else begin
            for (int i = 0; i < `KP_EVT_WIDTH; i++) begin
                if ((i == `KP_EVT_FLAG && flag_set) || (i == `KP_EVT_WAKE && wake_now)) begin
                    evt_status_q[i] <= 1'b1;
                end else if (wr_fire & wr_hit & w_strb_q[0]
                             & (wr_ofs == `KP_OFS_EVENT_CLEAR) & w_data_q[i]) begin
                    evt_status_q[i] <= 1'b0;
                end
            end
        end
    end

    // outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq          <= 1'b0;
            wake_req     <= 1'b0;
            pull_down_en <= '0;
        end else begin
            irq          <= (status_control_q[`KP_BIT_IRQ_EN] & flag_q)
                          | ((evt_status_q & evt_enable_q) != '0);
            wake_req     <= wake_now;
            pull_down_en <= pin_enable_q & invert;
        end
    end

    // read path
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= `KP_RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `KP_RESP_OKAY;
                s_axi_rdata  <= '0;
                if (s_axi_araddr[31:5] != '0) begin
                    s_axi_rresp <= `KP_RESP_SLVERR;
                end else begin
                    unique case (rd_ofs)
                        `KP_OFS_STATUS_CONTROL: s_axi_rdata <= {24'h0, status_view};
                        `KP_OFS_PIN_ENABLE:     s_axi_rdata <= {24'h0, pin_enable_q};
                        `KP_OFS_EVENT_STATUS:   s_axi_rdata <= {30'h0, evt_status_q};
                        `KP_OFS_EVENT_CLEAR:    s_axi_rdata <= '0;
                        `KP_OFS_EVENT_ENABLE:   s_axi_rdata <= {30'h0, evt_enable_q};
                        `KP_OFS_LOW_POWER:      s_axi_rdata <= {30'h0, low_power_q};
                        default:                s_axi_rresp <= `KP_RESP_SLVERR;
                    endcase
                end
            end else if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// *** hdl/pin_sync.sv ***
/*
 * two-stage synchroniser for one keypad pin.
 * assumes the pin may change at any time relative to aclk.
 */
`timescale 1ns/1ns
`default_nettype none
module pin_sync (
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // pin
    input  wire logic pin_in,
    output logic      pin_out
);
    logic meta_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_q  <= 1'b1;
            pin_out <= 1'b1;
        end else begin
            meta_q  <= pin_in;
            pin_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

// *** test/keypad_switches.sv ***
/*
 * keypad switches on the eight port pins.
 * assumes a pull-up on every pin unless the unit enables its pull-down.
 */
`timescale 1ns/1ns
`default_nettype none
module keypad_switches (
    // from the bench
    input  wire logic [7:0] press,
    input  wire logic [7:0] active_high,
    // pad side
    input  wire logic [7:0] pull_down_en,
    output logic      [7:0] pins
);
    // a released pin floats to its pull device
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (press[i]) pins[i] = active_high[i];
            else pins[i] = !pull_down_en[i];
        end
    end
endmodule
`default_nettype wire

// *** test/keypad_wake_unit_monitor.sv ***
/*
 * port checker of the keypad wake unit: bus timing, read-backs, irq, pull-downs.
 * assumes a bind onto keypad_wake_unit, one clock and a sync active-low reset.
 */
`timescale 1ns/1ns
`default_nettype none
module keypad_wake_unit_monitor #(
    parameter int PINS = 8
) (
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // register bus
    input wire logic [31:0] s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    // pads and processor
    input wire logic [7:0]  pull_down_en,
    input wire logic        irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [31:0] aw_q, w_q, ar_q;
    logic [7:0]  ctrl_q, pe_q;
    logic [1:0]  ee_q, age_q;
    // addresses and data as taken by the slave
    always_ff @(posedge aclk) begin
        if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
        if (s_axi_wvalid && s_axi_wready) w_q <= s_axi_wdata;
        if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
    end
    // shadow of the enables, age counts cycles since the last write landed
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= 8'h00;
            pe_q   <= 8'h00;
            ee_q   <= 2'h0;
            age_q  <= 2'h0;
        end else if ($rose(s_axi_bvalid) && s_axi_bresp == 2'h0) begin
            age_q <= 2'h0;
            if (aw_q == 32'h00) ctrl_q <= w_q[7:0];
            if (aw_q == 32'h04) pe_q <= w_q[7:0];
            if (aw_q == 32'h10) ee_q <= w_q[1:0];
        end else if (age_q != 2'h3) begin
            age_q <= age_q + 2'h1;
        end
    end
    property p_pd_low; pull_down_en[3:0] == 4'h0; endproperty
    a_pd_low: assert property (p_pd_low) else $error("pull-down on a lower pin");
    property p_pd; age_q == 2'h3 |-> pull_down_en == {pe_q[7:4] & ctrl_q[7:4], 4'h0};
    endproperty
    a_pd: assert property (p_pd) else $error("pull-down enables wrong");
    property p_masked; ctrl_q[1] == 1'b0 && ee_q == 2'h0 && age_q == 2'h3 |-> !irq;
    endproperty
    a_masked: assert property (p_masked) else $error("irq while masked");
    property p_irq_read;
        s_axi_rvalid && ar_q == 32'h0 && s_axi_rdata[3] && s_axi_rdata[1] |-> ##[0:2] irq;
    endproperty
    a_irq_read: assert property (p_irq_read) else $error("no irq for enabled flag");
    property p_ack_zero; s_axi_rvalid && ar_q == 32'h0 |-> !s_axi_rdata[2]; endproperty
    a_ack_zero: assert property (p_ack_zero) else $error("acknowledge bit read as 1");
    property p_unmapped;
        s_axi_rvalid && ar_q >= 32'h18 |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
    property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read data late");
    property p_b_done; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
    a_b_done: assert property (p_b_done) else $error("write response repeated");
    property p_aw_pulse; s_axi_awready |=> !s_axi_awready; endproperty
    a_aw_pulse: assert property (p_aw_pulse) else $error("awready longer than a cycle");
endmodule
bind keypad_wake_unit keypad_wake_unit_monitor #(.PINS(PINS)) keypad_wake_unit_monitor_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .pull_down_en, .irq
);
`default_nettype wire

// *** test/keypad_wake_unit_tb.sv ***
/*
 * bench of the keypad wake unit: register table, detection, acknowledge, irq, wake.
 * assumes the design, its monitor and the switch model are compiled first.
 */
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin \
    n_compared++; \
    if ((g) !== (e)) begin \
        errors++; \
        $display("Error at %0t: got %h expected %h", $time, g, e); \
    end \
end
module keypad_wake_unit_tb
    import keypad_pkg::*;
;
    typedef struct packed {
        logic [31:0] addr;
        byte_t       wdata;
        byte_t       rdata;
        logic [1:0]  resp;
    } row_t;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, irq, wake_req;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [7:0]  keypad_pins, pull_down_en, press, active_high;
    int          errors, n_compared;
    row_t        rows [6] = '{
        '{32'h00, 8'hff, 8'hf3, 2'h0},
        '{32'h04, 8'ha5, 8'ha5, 2'h0},
        '{32'h10, 8'hff, 8'h03, 2'h0},
        '{32'h0c, 8'hff, 8'h00, 2'h0},
        '{32'h14, 8'h02, 8'h02, 2'h0},
        '{32'h18, 8'hff, 8'h00, 2'h2}
    };
    keypad_wake_unit #(.PINS(8)) keypad_wake_unit_inst (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .keypad_pins, .pull_down_en,
        .irq, .wake_req
    );
    keypad_switches keypad_switches_inst (
        .press, .active_high, .pull_down_en, .pins(keypad_pins)
    );
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    task automatic print_verdict;
        if (errors == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge aclk);
    endtask
    task automatic wr(input logic [31:0] a, input logic [7:0] v);
        int n;
        n = 0;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= {24'h0, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            n++;
        end while (!s_axi_bvalid && n < 50);
        s_axi_bready <= 1'b0;
        @(posedge aclk);
        if (n >= 50) begin
            errors++;
            print_verdict();
        end
    endtask
    task automatic rc(input logic [31:0] a, input logic [7:0] e);
        int n;
        n = 0;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            n++;
        end while (!s_axi_rvalid && n < 50);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
        if (n >= 50) begin
            errors++;
            print_verdict();
        end
        `CHK(d, {24'h0, e})
    endtask
    initial begin
        aresetn       <= 1'b0;
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid  <= 1'b0;
        s_axi_bready  <= 1'b0;
        s_axi_arvalid <= 1'b0;
        s_axi_rready  <= 1'b0;
        s_axi_awaddr  <= 32'h0;
        s_axi_wdata   <= 32'h0;
        s_axi_araddr  <= 32'h0;
        s_axi_wstrb   <= 4'hf;
        press         <= 8'h00;
        active_high   <= 8'h00;
        tick(5);
        aresetn <= 1'b1;
        tick(1);
        for (int a = 0; a < 24; a += 4) rc(32'(a), 8'h00);
        `CHK({irq, wake_req, pull_down_en}, 10'h000)
        for (int i = 0; i < 6; i++) begin
            wr(rows[i].addr, rows[i].wdata);
            rc(rows[i].addr, rows[i].rdata);
            `CHK(r, rows[i].resp)
        end
        wr(32'h14, 8'h00);
        wr(32'h10, 8'h00);
        wr(32'h04, 8'h00);
        // edge-only, falling on pin 0, acknowledged while still pressed
        wr(32'h00, 8'h06);
        wr(32'h04, 8'h01);
        press <= 8'h01;
        tick(8);
        rc(32'h00, 8'h0a);
        `CHK(irq, 1'b1)
        wr(32'h00, 8'h06);
        rc(32'h00, 8'h02);
        press <= 8'h00;
        tick(8);
        rc(32'h00, 8'h02);
        // edge-and-level: acknowledge has no lasting effect while asserted
        wr(32'h00, 8'h03);
        press <= 8'h01;
        tick(8);
        rc(32'h00, 8'h0b);
        wr(32'h00, 8'h07);
        rc(32'h00, 8'h0b);
        press <= 8'h00;
        tick(8);
        wr(32'h00, 8'h07);
        rc(32'h00, 8'h03);
        // rising polarity on pin 7 with its pull-down
        active_high <= 8'h80;
        wr(32'h00, 8'h86);
        wr(32'h04, 8'h80);
        tick(8);
        `CHK(pull_down_en, 8'h80)
        wr(32'h00, 8'h86);
        press <= 8'h80;
        tick(8);
        rc(32'h00, 8'h8a);
        wr(32'h00, 8'h86);
        press <= 8'h00;
        tick(8);
        rc(32'h00, 8'h82);
        // lower pin ignores polarity bits; flag polled with irq masked
        wr(32'h00, 8'hf0);
        wr(32'h04, 8'h08);
        tick(4);
        `CHK(pull_down_en, 8'h00)
        press <= 8'h08;
        tick(8);
        rc(32'h00, 8'hf8);
        `CHK(irq, 1'b0)
        press <= 8'h02;
        wr(32'h00, 8'hf4);
        tick(8);
        rc(32'h00, 8'hf0);
        press <= 8'h00;
        // stop-mode wake through the event registers
        wr(32'h00, 8'h04);
        wr(32'h04, 8'h01);
        wr(32'h14, 8'h01);
        wr(32'h10, 8'h02);
        press <= 8'h01;
        tick(8);
        `CHK({wake_req, irq}, 2'h3)
        rc(32'h08, 8'h03);
        press <= 8'h00;
        tick(8);
        wr(32'h14, 8'h00);
        wr(32'h0c, 8'h03);
        rc(32'h08, 8'h00);
        tick(2);
        `CHK(irq, 1'b0)
        // wait mode: a detected edge raises the wake event
        wr(32'h14, 8'h02);
        press <= 8'h01;
        tick(8);
        rc(32'h08, 8'h03);
        press <= 8'h00;
        print_verdict();
    end
endmodule
`default_nettype wire
